// *** hw/dtc_timer_top.sv ***
/*
  dual timer/counter with overflow toggle outputs and an AXI4-Lite register slave.
  assumes pins are asynchronous to mclk; count pins are resolved outside from out/oeN.
*/
`timescale 1ns/1ns
module dtc_timer_top (
  input wire logic mclk,
  input wire logic rst,
  input dtc_pkg::dtc_axi_req_t axiReq,
  output dtc_pkg::dtc_axi_rsp_t axiRsp,
  input wire logic countPin0In,
  output logic countPin0Out,
  output logic countPin0OeN,
  input wire logic countPin1In,
  output logic countPin1Out,
  output logic countPin1OeN,
  input wire logic levelIn0,
  input wire logic levelIn1,
  output logic irq,
  output logic timer1OverflowTick
);
  import dtc_pkg::*;

  dtc_state_t st_reg;
  dtc_state_t st_next;

  logic tick;
  logic fall0;
  logic fall1;
  logic lvl0;
  logic lvl1;
  dtc_mode_t mode0;
  dtc_mode_t mode1;
  logic t0Split;
  logic en0;
  logic en1;
  logic fire0;
  logic fire1;
  logic fireHi;
  logic [8:0] lo0Inc;
  logic [8:0] hiInc;
  logic [16:0] count0;
  logic [16:0] count1;
  logic ovf0Ev;
  logic ovf1Ev;
  logic hiOvf;
  logic flag1Set;
  logic wrFire;
  logic wrEn;
  logic [32:0] wrInfo;
  logic [32:0] rdInfo;
  logic wrMode;
  logic wrCtrl;
  logic wrT0Lo;
  logic wrT0Hi;
  logic wrT1Lo;
  logic wrT1Hi;
  logic wrPort;
  logic wrStat;
  logic wrMask;
  logic wr0;
  logic wr1;

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  dtc_edge_sync uSyncCount0 (.mclk(mclk), .rst(rst), .pinIn(countPin0In), .sampleTick(tick), .level(), .fall(fall0));
  dtc_edge_sync uSyncCount1 (.mclk(mclk), .rst(rst), .pinIn(countPin1In), .sampleTick(tick), .level(), .fall(fall1));
  dtc_edge_sync uSyncLevel0 (.mclk(mclk), .rst(rst), .pinIn(levelIn0), .sampleTick(tick), .level(lvl0), .fall());
  dtc_edge_sync uSyncLevel1 (.mclk(mclk), .rst(rst), .pinIn(levelIn1), .sampleTick(tick), .level(lvl1), .fall());

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [16:0] stepCount(input dtc_mode_t mode, input logic [7:0] hi, input logic [7:0] lo);
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0] v8;
    v13 = {1'b0, hi, lo[4:0]} + 14'h1;
    v16 = {1'b0, hi, lo} + 17'h1;
    v8 = {1'b0, lo} + 9'h1;
    stepCount = {1'b0, hi, lo};
    unique case (mode)
      // 13-bit count, upper low bits untouched
      MODE_13BIT: stepCount = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
      MODE_16BIT: stepCount = v16;
      MODE_RELOAD: stepCount = {v8[8], hi, v8[8] ? hi : v8[7:0]};
      MODE_SPLIT: stepCount = {1'b0, hi, lo};
    endcase
  endfunction

  function automatic logic [32:0] readReg(input logic [7:0] addr, input dtc_state_t s);
    logic [31:0] d;
    logic hit;
    d = 32'h0;
    hit = 1'b1;
    case (addr)
      OFS_MODE: d[7:0] = s.timerMode;
      OFS_CTRL:
      begin
        d[RUN0_BIT] = s.run0;
        d[OVF0_BIT] = s.ovf0;
        d[RUN1_BIT] = s.run1;
        d[OVF1_BIT] = s.ovf1;
      end
      OFS_T0LO: d[7:0] = s.t0Lo;
      OFS_T0HI: d[7:0] = s.t0Hi;
      OFS_T1LO: d[7:0] = s.t1Lo;
      OFS_T1HI: d[7:0] = s.t1Hi;
      OFS_PORTCFG:
      begin
        d[TOG0_BIT] = s.tog0En;
        d[TOG1_BIT] = s.tog1En;
      end
      OFS_INTSTAT: d[1:0] = s.intStatus;
      OFS_INTMASK: d[1:0] = s.intMask;
      default: hit = 1'b0;
    endcase
    readReg = {hit, d};
  endfunction

  // ------------------------------------------------------------
  // count enables
  // ------------------------------------------------------------
  // machine cycle tick
  assign tick = (st_reg.prescale == MC_LAST);
  assign mode0 = dtc_mode_t'(st_reg.timerMode[MODE0_LSB +: 2]);
  assign mode1 = dtc_mode_t'(st_reg.timerMode[MODE1_LSB +: 2]);
  assign t0Split = (mode0 == MODE_SPLIT);
  assign en0 = st_reg.run0 & (~st_reg.timerMode[HOLD0_BIT] | lvl0);
  // timer one stops in mode three
  assign en1 = st_reg.run1 & (~st_reg.timerMode[HOLD1_BIT] | lvl1) & (mode1 != MODE_SPLIT);
  assign fire0 = tick & en0 & (st_reg.timerMode[SRC0_BIT] ? fall0 : 1'b1);
  assign fire1 = tick & en1 & (st_reg.timerMode[SRC1_BIT] ? fall1 : 1'b1);
  // high byte counts cycles on timer one run
  assign fireHi = t0Split & tick & st_reg.run1;
  assign lo0Inc = {1'b0, st_reg.t0Lo} + 9'h1;
  assign hiInc = {1'b0, st_reg.t0Hi} + 9'h1;
  assign count0 = stepCount(mode0, st_reg.t0Hi, st_reg.t0Lo);
  assign count1 = stepCount(mode1, st_reg.t1Hi, st_reg.t1Lo);
  assign ovf0Ev = fire0 & (t0Split ? lo0Inc[8] : count0[16]);
  assign ovf1Ev = fire1 & count1[16];
  assign hiOvf = fireHi & hiInc[8];
  // timer one overflow loses its flag in split mode
  assign flag1Set = t0Split ? hiOvf : ovf1Ev;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  assign wrFire = st_reg.awHeld & st_reg.wHeld & ~st_reg.rsp.bvalid;
  assign wrInfo = readReg(st_reg.awAddr, st_reg);
  assign rdInfo = readReg(axiReq.araddr, st_reg);
  assign wrEn = wrFire & st_reg.wStrb[0];
  assign wrMode = wrEn & (st_reg.awAddr == OFS_MODE);
  assign wrCtrl = wrEn & (st_reg.awAddr == OFS_CTRL);
  assign wrT0Lo = wrEn & (st_reg.awAddr == OFS_T0LO);
  assign wrT0Hi = wrEn & (st_reg.awAddr == OFS_T0HI);
  assign wrT1Lo = wrEn & (st_reg.awAddr == OFS_T1LO);
  assign wrT1Hi = wrEn & (st_reg.awAddr == OFS_T1HI);
  assign wrPort = wrEn & (st_reg.awAddr == OFS_PORTCFG);
  assign wrStat = wrEn & (st_reg.awAddr == OFS_INTSTAT);
  assign wrMask = wrEn & (st_reg.awAddr == OFS_INTMASK);
  assign wr0 = wrT0Lo | wrT0Hi | wrMode;
  assign wr1 = wrT1Lo | wrT1Hi | wrMode;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.prescale = tick ? 3'h0 : st_reg.prescale + 3'h1;
    if (axiReq.awvalid && st_reg.rsp.awready)
    begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = axiReq.awaddr;
      st_next.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && st_reg.rsp.wready)
    begin
      st_next.wHeld = 1'b1;
      st_next.wData = axiReq.wdata;
      st_next.wStrb = axiReq.wstrb;
      st_next.rsp.wready = 1'b0;
    end
    if (wrFire)
    begin
      st_next.awHeld = 1'b0;
      st_next.wHeld = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = wrInfo[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_reg.rsp.bvalid && axiReq.bready)
    begin
      st_next.rsp.bvalid = 1'b0;
      st_next.rsp.awready = 1'b1;
      st_next.rsp.wready = 1'b1;
    end
    if (axiReq.arvalid && st_reg.rsp.arready)
    begin
      st_next.rsp.arready = 1'b0;
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata = rdInfo[31:0];
      st_next.rsp.rresp = rdInfo[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_reg.rsp.rvalid && axiReq.rready)
    begin
      st_next.rsp.rvalid = 1'b0;
      st_next.rsp.arready = 1'b1;
    end
    if (wrMode)
    begin
      st_next.timerMode = st_reg.wData[7:0];
    end
    if (wrCtrl)
    begin
      st_next.run0 = st_reg.wData[RUN0_BIT];
      st_next.run1 = st_reg.wData[RUN1_BIT];
      st_next.ovf0 = st_reg.wData[OVF0_BIT];
      st_next.ovf1 = st_reg.wData[OVF1_BIT];
    end
    if (wrPort)
    begin
      st_next.tog0En = st_reg.wData[TOG0_BIT];
      st_next.tog1En = st_reg.wData[TOG1_BIT];
    end
    if (wrMask)
    begin
      st_next.intMask = st_reg.wData[1:0];
    end
    if (t0Split)
    begin
      if (fire0)
      begin
        st_next.t0Lo = lo0Inc[7:0];
      end
      if (fireHi)
      begin
        st_next.t0Hi = hiInc[7:0];
      end
    end
    else if (fire0)
    begin
      st_next.t0Hi = count0[15:8];
      st_next.t0Lo = count0[7:0];
    end
    if (fire1)
    begin
      st_next.t1Hi = count1[15:8];
      st_next.t1Lo = count1[7:0];
    end
    if (wrT0Lo)
    begin
      st_next.t0Lo = st_reg.wData[7:0];
    end
    if (wrT0Hi)
    begin
      st_next.t0Hi = st_reg.wData[7:0];
    end
    if (wrT1Lo)
    begin
      st_next.t1Lo = st_reg.wData[7:0];
    end
    if (wrT1Hi)
    begin
      st_next.t1Hi = st_reg.wData[7:0];
    end
    // overflow sets flag, over a clear
    if (ovf0Ev)
    begin
      st_next.ovf0 = 1'b1;
    end
    // high byte drives timer one flag in split mode, else timer one overflow
    if (flag1Set)
    begin
      st_next.ovf1 = 1'b1;
    end
    st_next.intStatus = (st_reg.intStatus & ~(wrStat ? st_reg.wData[1:0] : 2'h0)) | {flag1Set, ovf0Ev};
    st_next.irq = |(st_next.intStatus & st_next.intMask);
    st_next.serialTick = ovf1Ev;
    if (st_next.tog0En && !st_reg.tog0En)
    begin
      st_next.pinOut0 = 1'b1;
    end
    else if (st_reg.tog0En && ovf0Ev)
    begin
      st_next.pinOut0 = ~st_reg.pinOut0;
    end
    if (st_next.tog1En && !st_reg.tog1En)
    begin
      st_next.pinOut1 = 1'b1;
    end
    else if (st_reg.tog1En && ovf1Ev)
    begin
      st_next.pinOut1 = ~st_reg.pinOut1;
    end
    st_next.pinOeN0 = ~st_next.tog0En;
    st_next.pinOeN1 = ~st_next.tog1En;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.rsp.awready <= 1'b1;
      st_reg.rsp.wready <= 1'b1;
      st_reg.rsp.arready <= 1'b1;
      st_reg.pinOut0 <= 1'b1;
      st_reg.pinOut1 <= 1'b1;
      st_reg.pinOeN0 <= 1'b1;
      st_reg.pinOeN1 <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign axiRsp = st_reg.rsp;
  assign countPin0Out = st_reg.pinOut0;
  assign countPin0OeN = st_reg.pinOeN0;
  assign countPin1Out = st_reg.pinOut1;
  assign countPin1OeN = st_reg.pinOeN1;
  assign irq = st_reg.irq;
  assign timer1OverflowTick = st_reg.serialTick;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  tick_period_a: assert property (tick |=> !tick [*5] ##1 tick)
    else $error("machine cycle tick not every six clocks");
  mode1_count_a: assert property ((fire0 && !wr0 && mode0 == MODE_16BIT && !st_reg.timerMode[SRC0_BIT])
    |=> {st_reg.t0Hi, st_reg.t0Lo} == $past({st_reg.t0Hi, st_reg.t0Lo}) + 16'h1)
    else $error("16-bit timer did not step by one");
  fall_count_a: assert property ((fall0 && en0 && !wr0 && st_reg.timerMode[SRC0_BIT] && mode0 == MODE_16BIT)
    |=> {st_reg.t0Hi, st_reg.t0Lo} == $past({st_reg.t0Hi, st_reg.t0Lo}) + 16'h1)
    else $error("falling edge not counted in next cycle");
  gate_hold_a: assert property ((!en0 && !wr0 && !t0Split) |=> st_reg.t0Lo == $past(st_reg.t0Lo))
    else $error("timer zero counted while disabled");
  ovf_flag_a: assert property (ovf0Ev |=> st_reg.ovf0 && st_reg.intStatus[INT_T0_BIT])
    else $error("overflow did not set flag");
  reload_lo_a: assert property ((fire0 && mode0 == MODE_RELOAD && st_reg.t0Lo == 8'hFF && !wr0)
    |=> st_reg.t0Lo == st_reg.t0Hi && st_reg.t0Hi == $past(st_reg.t0Hi))
    else $error("reload did not copy high byte");
  t1_stop_a: assert property ((mode1 == MODE_SPLIT && !wr1)
    |=> st_reg.t1Lo == $past(st_reg.t1Lo) && st_reg.t1Hi == $past(st_reg.t1Hi))
    else $error("timer one moved in mode three");
  split_hi_a: assert property ((fireHi && st_reg.t0Hi == 8'hFF && !wr0) |=> st_reg.ovf1 && st_reg.t0Hi == 8'h00)
    else $error("split high byte overflow missed timer one flag");
  split_t1_a: assert property ((t0Split && ovf1Ev && !hiOvf && !st_reg.ovf1 && !wrCtrl)
    |=> !st_reg.ovf1 && timer1OverflowTick)
    else $error("timer one overflow in split mode misrouted");
  toggle_out_a: assert property ((st_reg.tog0En && st_next.tog0En && ovf0Ev)
    |=> countPin0Out != $past(countPin0Out) && !countPin0OeN)
    else $error("toggle output did not invert");
  toggle_on_a: assert property ((!st_reg.tog0En && st_next.tog0En) |=> countPin0Out ##1 countPin0Out || $past(ovf0Ev))
    else $error("toggle output not high after turn-on");
  flag_hold_a: assert property ((st_reg.ovf0 && !wrCtrl) |=> st_reg.ovf0)
    else $error("overflow flag dropped without write");
  run_keep_a: assert property ((wrCtrl && !wr0 && !st_reg.run0 && st_reg.wData[RUN0_BIT])
    |=> st_reg.t0Lo == $past(st_reg.t0Lo) && st_reg.run0)
    else $error("starting timer altered count");
  bvalid_hold_a: assert property ((axiRsp.bvalid && !axiReq.bready) |=> axiRsp.bvalid)
    else $error("write response dropped before ready");

endmodule

// *** hw/dtc_pkg.sv ***
/*
  constants, field layout, register offsets and carrier types of the dual timer/counter.
  assumes a single 25 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// Operation
// - timer function counts once per machine cycle of six clocks
// - counter function samples count pin each machine cycle, counts on high then low
// - new count visible next cycle; edge takes two machine cycles
// - per timer a source select bit and a two-bit mode field
// - mode zero: 13 bits from high byte and low five bits of low byte
// - rollover of the active counter sets that timer's overflow flag
// - counting only when run bit set and hold select clear or level input high
// - setting run bit resumes counting without touching count bytes
// - hold select at mode bit seven for timer one, bit three for timer zero
// - mode one: like mode zero but all sixteen bits count
// - mode two: low byte counts, overflow reloads it from high byte
// - timer one in mode three stops and holds, like run bit cleared
// - timer zero mode three: low byte is own 8-bit counter with timer zero controls
// - timer zero mode three: high byte counts cycles, uses timer one run and flag
// - then timer one runs by leaving mode three; overflow goes to serial tick and toggle output, not its flag
// - toggle enable set: count pin output inverts at every overflow
// - toggle turned on: pin output is one until first overflow
package dtc_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [2:0] MC_CLOCKS = 3'h6;
  localparam logic [2:0] MC_LAST = MC_CLOCKS - 3'h1;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_T0LO = 8'h08;
  localparam logic [7:0] OFS_T0HI = 8'h0C;
  localparam logic [7:0] OFS_T1LO = 8'h10;
  localparam logic [7:0] OFS_T1HI = 8'h14;
  localparam logic [7:0] OFS_PORTCFG = 8'h18;
  localparam logic [7:0] OFS_INTSTAT = 8'h1C;
  localparam logic [7:0] OFS_INTMASK = 8'h20;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE0_LSB = 0;
  localparam int SRC0_BIT = 2;
  localparam int HOLD0_BIT = 3;
  localparam int MODE1_LSB = 4;
  localparam int SRC1_BIT = 6;
  localparam int HOLD1_BIT = 7;
  localparam int RUN0_BIT = 4;
  localparam int OVF0_BIT = 5;
  localparam int RUN1_BIT = 6;
  localparam int OVF1_BIT = 7;
  localparam int TOG0_BIT = 0;
  localparam int TOG1_BIT = 1;
  localparam int INT_T0_BIT = 0;
  localparam int INT_T1_BIT = 1;

  // ------------------------------------------------------------
  // reset values and responses
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } dtc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dtc_axi_rsp_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sample;
  } dtc_sync_t;

  typedef struct packed {
    logic [2:0] prescale;
    logic [7:0] timerMode;
    logic run0;
    logic run1;
    logic ovf0;
    logic ovf1;
    logic [7:0] t0Lo;
    logic [7:0] t0Hi;
    logic [7:0] t1Lo;
    logic [7:0] t1Hi;
    logic tog0En;
    logic tog1En;
    logic pinOut0;
    logic pinOut1;
    logic pinOeN0;
    logic pinOeN1;
    logic serialTick;
    logic [1:0] intStatus;
    logic [1:0] intMask;
    logic irq;
    dtc_axi_rsp_t rsp;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
  } dtc_state_t;

endpackage

// *** hw/dtc_edge_sync.sv ***
/*
  two-flop synchroniser with a once-per-machine-cycle sample and falling edge detect.
  assumes sampleTick is a one-clock pulse from the same clock domain.
*/
`timescale 1ns/1ns
module dtc_edge_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pinIn,
  input wire logic sampleTick,
  output logic level,
  output logic fall
);
  import dtc_pkg::*;

  dtc_sync_t st_reg;
  dtc_sync_t st_next;

  // ------------------------------------------------------------
  // sampling
  // ------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = pinIn;
    st_next.sync2 = st_reg.sync1;
    if (sampleTick)
    begin
      st_next.sample = st_reg.sync2;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.sync2;
  assign fall = sampleTick & st_reg.sample & ~st_reg.sync2;

endmodule

// *** dv/dtc_pin_model.sv ***
/*
  pin-side partner: count pins and level inputs of both timers.
  assumes tasks are called just after a rising edge of mclk.
*/
`timescale 1ns/1ns
module dtc_pin_model (
  input wire logic mclk,
  input wire logic out0,
  input wire logic oeN0,
  input wire logic out1,
  input wire logic oeN1,
  output logic pin0,
  output logic pin1,
  output logic level0,
  output logic level1
);
  logic drive0 = 1'b1;
  logic drive1 = 1'b1;
  initial level0 = 1'b0;
  initial level1 = 1'b0;
  // ------------------------------------------------------------
  // wire level from both drivers
  // ------------------------------------------------------------
  assign pin0 = oeN0 ? drive0 : out0;
  assign pin1 = oeN1 ? drive1 : out1;
  task automatic pulse(input int idx);
    if (idx == 0) drive0 <= 1'b0;
    else drive1 <= 1'b0;
    repeat (8) @(posedge mclk);
    if (idx == 0) drive0 <= 1'b1;
    else drive1 <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
  task automatic setLevel(input int idx, input logic v);
    if (idx == 0) level0 <= v;
    else level1 <= v;
  endtask
endmodule

// *** dv/dtc_timer_bench.sv ***
/*
  self-checking bench of the dual timer/counter, AXI4-Lite side and pins.
  assumes dtc_timer_top and dtc_pin_model; one clock of 40 ns.
*/
`timescale 1ns/1ns
module dtc_timer_bench;
  import dtc_pkg::*;
  logic mclk;
  logic rst;
  dtc_axi_req_t req;
  dtc_axi_rsp_t rsp;
  logic pin0, pin1, level0, level1, out0, oeN0, out1, oeN1, irq, t1Tick;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] rl;
  int errors = 0;
  int checkCount = 0;
  int n;
  int k;
  dtc_timer_top dtc_timer_top_inst (.mclk(mclk), .rst(rst), .axiReq(req), .axiRsp(rsp),
    .countPin0In(pin0), .countPin0Out(out0), .countPin0OeN(oeN0), .countPin1In(pin1),
    .countPin1Out(out1), .countPin1OeN(oeN1), .levelIn0(level0), .levelIn1(level1),
    .irq(irq), .timer1OverflowTick(t1Tick));
  dtc_pin_model dtc_pin_model_inst (.mclk(mclk), .out0(out0), .oeN0(oeN0), .out1(out1),
    .oeN1(oeN1), .pin0(pin0), .pin1(pin1), .level0(level0), .level1(level1));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    bit aw;
    bit w;
    bit b;
    int i;
    bq.push_back(r);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    aw = 1;
    w = 1;
    b = 0;
    // bready one cycle behind bvalid
    while (!b)
    begin
      @(posedge mclk);
      b = (rsp.bvalid === 1'b1) && (req.bready === 1'b1);
      if (aw && rsp.awready === 1'b1) aw = 0;
      if (w && rsp.wready === 1'b1) w = 0;
      if (!aw) req.awvalid <= 1'b0;
      if (!w) req.wvalid <= 1'b0;
      req.bready <= !b && (rsp.bvalid === 1'b1);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    bit ar;
    rq.push_back({r, 24'h0, d});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    ar = 1;
    while (ar)
    begin
      @(posedge mclk);
      if (rsp.arready === 1'b1) ar = 0;
    end
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1) @(posedge mclk);
  endtask
  task automatic waitIrq();
    int i;
    for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge mclk);
  endtask
  // cycles between two events: sel 0 pin toggle, sel 1 timer one tick
  task automatic gap(input int sel, output int cnt);
    logic last;
    int i;
    last = out0;
    for (i = 0; i < 400 && !(sel ? t1Tick === 1'b1 : out0 !== last); i++) @(posedge mclk);
    last = out0;
    @(posedge mclk);
    cnt = 1;
    for (i = 0; i < 400 && !(sel ? t1Tick === 1'b1 : out0 !== last); i++)
    begin
      @(posedge mclk);
      cnt++;
    end
  endtask
  // ------------------------------------------------------------
  // result monitor
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rsp.rvalid === 1'b1 && rq.size() > 0) check("read", {rsp.rresp, rsp.rdata}, rq.pop_front());
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1 && bq.size() > 0) check("bresp", {32'h0, rsp.bresp}, {32'h0, bq.pop_front()});
  end
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    stop_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    req = '0;
    rst = 1'b1;
    void'($urandom(69657));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    req.rready <= 1'b1;
    @(posedge mclk);
    check("pin0 out", {33'h0, out0}, 34'h1);
    check("pin0 oe", {33'h0, oeN0}, 34'h1);
    check("pin1 out", {33'h0, out1}, 34'h1);
    check("pin1 oe", {33'h0, oeN1}, 34'h1);
    for (n = 0; n <= 32; n += 4) rd(8'(n), RST_BYTE);
    rd(8'h24, 8'h00, RESP_SLVERR);
    wr(8'h24, 8'hFF, RESP_SLVERR);
    // gated timer function, mode zero then mode one
    for (k = 0; k < 2; k++)
    begin
      wr(OFS_MODE, 8'(k) | 8'(1 << HOLD0_BIT));
      wr(OFS_T0LO, 8'hFE);
      wr(OFS_T0HI, 8'hFF);
      wr(OFS_INTMASK, 8'h01);
      dtc_pin_model_inst.setLevel(0, 1'b1);
      repeat (4) @(posedge mclk);
      wr(OFS_CTRL, 8'h10);
      waitIrq();
      dtc_pin_model_inst.setLevel(0, 1'b0);
      check("irq", {33'h0, irq}, 34'h1);
      repeat (20) @(posedge mclk);
      rd(OFS_T0LO, k ? 8'h00 : 8'hE0);
      rd(OFS_T0HI, 8'h00);
      rd(OFS_CTRL, 8'h30);
      rd(OFS_INTSTAT, 8'h01);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_INTSTAT, 8'h01);
      rd(OFS_CTRL, 8'h00);
      check("irq", {33'h0, irq}, 34'h0);
    end
    // counter function on the count pin
    wr(OFS_INTMASK, 8'h00);
    n = 1 + $urandom % 5;
    wr(OFS_MODE, 8'h05);
    wr(OFS_T0LO, 8'(256 - n));
    wr(OFS_T0HI, 8'hFF);
    wr(OFS_CTRL, 8'h10);
    repeat (n + 1) dtc_pin_model_inst.pulse(0);
    repeat (20) @(posedge mclk);
    rd(OFS_T0LO, 8'h01);
    rd(OFS_T0HI, 8'h00);
    check("irq masked", {33'h0, irq}, 34'h0);
    wr(OFS_INTMASK, 8'h01);
    check("irq", {33'h0, irq}, 34'h1);
    wr(OFS_INTSTAT, 8'h01);
    check("irq", {33'h0, irq}, 34'h0);
    // auto-reload with toggle output
    rl = 8'hF8 + 8'($urandom % 7);
    wr(OFS_MODE, 8'h02);
    wr(OFS_T0HI, rl);
    wr(OFS_T0LO, rl);
    wr(OFS_PORTCFG, 8'h01);
    check("pin0 out", {33'h0, out0}, 34'h1);
    check("pin0 oe", {33'h0, oeN0}, 34'h0);
    wr(OFS_CTRL, 8'h10);
    gap(0, n);
    check("toggle gap", 34'(n), 34'((256 - rl) * 6));
    rd(OFS_T0HI, rl);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_PORTCFG, 8'h00);
    check("pin0 oe", {33'h0, oeN0}, 34'h1);
    // timer one stopped, then split mode
    wr(OFS_MODE, 8'h30);
    wr(OFS_T1LO, 8'h55);
    wr(OFS_CTRL, 8'h40);
    repeat (30) @(posedge mclk);
    rd(OFS_T1LO, 8'h55);
    wr(OFS_T0HI, 8'hFA);
    wr(OFS_PORTCFG, 8'h02);
    check("pin1 oe", {33'h0, oeN1}, 34'h0);
    check("pin1 out", {33'h0, out1}, 34'h1);
    wr(OFS_T0LO, 8'h77);
    wr(OFS_T1HI, 8'hFD);
    wr(OFS_T1LO, 8'hFD);
    wr(OFS_INTSTAT, 8'h03);
    wr(OFS_INTMASK, 8'h02);
    wr(OFS_MODE, 8'h23);
    gap(1, n);
    check("tick gap", 34'(n), 34'd18);
    waitIrq();
    rd(OFS_INTSTAT, 8'h02);
    rd(OFS_CTRL, 8'hC0);
    rd(OFS_T0LO, 8'h77);
    wr(OFS_MODE, 8'h33);
    n = 0;
    repeat (100)
    begin
      @(posedge mclk);
      n += t1Tick;
    end
    check("ticks held", 34'(n), 34'd0);
    // timer one counter function behind its hold select
    wr(OFS_PORTCFG, 8'h00);
    check("pin1 oe", {33'h0, oeN1}, 34'h1);
    wr(OFS_MODE, 8'hD0);
    wr(OFS_T1LO, 8'hFE);
    wr(OFS_T1HI, 8'hFF);
    wr(OFS_CTRL, 8'h40);
    dtc_pin_model_inst.pulse(1);
    dtc_pin_model_inst.setLevel(1, 1'b1);
    repeat (2) dtc_pin_model_inst.pulse(1);
    repeat (20) @(posedge mclk);
    rd(OFS_T1LO, 8'h00);
    rd(OFS_CTRL, 8'hC0);
    stop_test();
  end
endmodule
